// *** ufc_consts.svh ***
`ifndef UFC_CONSTS_SVH
`define UFC_CONSTS_SVH
// register offsets (word index on the plain port, the last two on bank 1)
`define UFC_A_IER       4'h0
`define UFC_A_FCR       4'h1
`define UFC_A_LCR       4'h2
`define UFC_A_MCR       4'h3
`define UFC_A_EFR       4'h4
`define UFC_A_RESUME_CHAR_FIRST      4'h5
`define UFC_A_RESUME_CHAR_SECOND      4'h6
`define UFC_A_PAUSE_CHAR_FIRST     4'h7
`define UFC_A_PAUSE_CHAR_SECOND     4'h8
`define UFC_A_TXLVL     4'h9
`define UFC_A_RXLVL     4'hA
`define UFC_A_FLWH      4'hB
`define UFC_A_FLWL      4'hC
`define UFC_A_DIVLO     4'hD
`define UFC_A_DIVHI     4'hE
`define UFC_A_PRES      4'hF
`define UFC_A_ADDITIONAL_FEATURE_CTRL_1     4'h0
`define UFC_A_ISR       4'h1
// field positions
`define UFC_EFR_RTS     6
`define UFC_EFR_CTS     7
`define UFC_EFR_SPEC    5
`define UFC_ADDITIONAL_FEATURE_CTRL_1_MAP   2
`define UFC_MCR_PRE4    7
`define UFC_IER_RX      0
`define UFC_IER_THR     1
`define UFC_IER_XOFF    5
`define UFC_IER_CTS     7
// reset values
`define UFC_RST_BYTE    8'h00
`define UFC_RST_DIV     16'h0001
// interrupt id codes
`define UFC_ID_NONE     8'h01
`define UFC_ID_RXTO     8'h0C
`define UFC_ID_RXRDY    8'h04
`define UFC_ID_THR      8'h02
`define UFC_ID_XOFF     8'h10
`define UFC_ID_CTS      8'h20
// timing
`define UFC_TO_CHARS    4
`define UFC_OVS         16
`define UFC_FIFO_MAX    8'd128
`endif

// *** ufc_pkg.sv ***
package ufc_pkg;
  typedef logic [7:0] ufc_byte_t;
  typedef enum logic [1:0] {UFC_SW_IDLE, UFC_SW_HALF} ufc_match_e;
endpackage : ufc_pkg

// *** ufc_flow_baud.sv ***
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`include "ufc_consts.svh"
module ufc_flow_baud (
  input  wire logic         clock_in,
  input  wire logic         rst_n_in,
  input  wire logic         clk_en_in,
  input  wire logic [3:0]   addr_in,
  input  wire logic         bank_in,
  input  wire ufc_pkg::ufc_byte_t wdata_in,
  input  wire logic         wr_in,
  input  wire logic         rd_in,
  output ufc_pkg::ufc_byte_t rdata_out,
  input  wire logic         rx_valid_in,
  input  wire ufc_pkg::ufc_byte_t rx_char_in,
  input  wire logic         rx_stop_in,
  input  wire logic [7:0]   rx_count_in,
  input  wire logic         rhr_read_in,
  input  wire logic         tx_char_done_in,
  input  wire logic         thr_empty_in,
  input  wire logic         cts_n_in,
  input  wire logic         dsr_n_in,
  input  wire logic         modem_rts_n_in,
  input  wire logic         modem_dtr_n_in,
  output logic              rx_push_out,
  output logic              tx_allow_out,
  output logic              send_xoff_out,
  output logic              send_xon_out,
  output logic              rts_n_out,
  output logic              dtr_n_out,
  output logic              baud16_out,
  output logic              irq_out
);
  import ufc_pkg::*;

  ufc_byte_t ier_ff, fcr_ff, lcr_ff, mcr_ff, efr_ff, additional_feature_ctrl_1_ff;
  ufc_byte_t resume_char_first_ff, resume_char_second_ff, pause_char_first_ff, pause_char_second_ff;
  ufc_byte_t txlvl_ff, rxlvl_ff, flwh_ff, flwl_ff, pres_ff;
  logic [15:0] div_ff;
  logic        hw_en, sw_en, dbl, ext_mode, cts_line, cts_prev_ff;
  logic        cts_flag_ff, xoff_flag_ff, thr_flag_ff, halted_ff;
  logic        rts_off_ff, xoff_sent_ff, to_flag_ff;
  logic [7:0]  hi_lvl, lo_lvl, rx_trig, cmask;
  logic        on1, on2, of1, of2, spec_hit, rx_rdy;
  ufc_match_e  m_on_ff, m_off_ff;
  ufc_byte_t   isr_id;

  // flow configuration decode
  assign hw_en    = efr_ff[`UFC_EFR_RTS] & efr_ff[`UFC_EFR_CTS];
  assign sw_en    = |efr_ff[3:0];
  assign dbl      = &efr_ff[1:0] | &efr_ff[3:2];
  assign ext_mode = |{txlvl_ff, rxlvl_ff, flwh_ff, flwl_ff};
  // pin level high is the remote's stop request
  assign cts_line = additional_feature_ctrl_1_ff[`UFC_ADDITIONAL_FEATURE_CTRL_1_MAP] ? dsr_n_in : cts_n_in;

  // thresholds, legacy table or extended counts
  always_comb begin
    unique case (fcr_ff[7:6])
      2'b00: begin hi_lvl = 8'd8;  lo_lvl = 8'd0;  end
      2'b01: begin hi_lvl = 8'd16; lo_lvl = 8'd7;  end
      2'b10: begin hi_lvl = 8'd24; lo_lvl = 8'd15; end
      2'b11: begin hi_lvl = 8'd28; lo_lvl = 8'd23; end
    endcase
    rx_trig = hi_lvl;
    if (ext_mode) begin
      hi_lvl  = (flwh_ff > `UFC_FIFO_MAX) ? `UFC_FIFO_MAX : flwh_ff;
      lo_lvl  = (flwl_ff > `UFC_FIFO_MAX) ? `UFC_FIFO_MAX : flwl_ff;
      rx_trig = rxlvl_ff;
    end
  end

  // word length mask for comparisons
  always_comb begin
    unique case (lcr_ff[1:0])
      2'b00: cmask = 8'h1F;
      2'b01: cmask = 8'h3F;
      2'b10: cmask = 8'h7F;
      2'b11: cmask = 8'hFF;
    endcase
  end
  assign on1 = ((rx_char_in ^ resume_char_first_ff) & cmask) == 8'h00;
  assign on2 = ((rx_char_in ^ resume_char_second_ff) & cmask) == 8'h00;
  assign of1 = ((rx_char_in ^ pause_char_first_ff) & cmask) == 8'h00;
  assign of2 = ((rx_char_in ^ pause_char_second_ff) & cmask) == 8'h00;
  assign spec_hit = efr_ff[`UFC_EFR_SPEC] & of2;

  // match strobes for single or double character mode
  logic xoff_hit, xon_hit, flow_char;
  always_comb begin
    xoff_hit  = 1'b0;
    xon_hit   = 1'b0;
    flow_char = 1'b0;
    if (rx_valid_in & sw_en) begin
      if (dbl) begin
        xoff_hit  = (m_off_ff == UFC_SW_HALF) & of2;
        xon_hit   = (m_on_ff == UFC_SW_HALF) & on2;
        flow_char = of1 | on1 | xoff_hit | xon_hit;
      end else begin
        xoff_hit  = of1;
        xon_hit   = on1;
        flow_char = of1 | on1;
      end
    end
  end
  // matched flow characters bypass the fifo
  assign rx_push_out = rx_valid_in & ~flow_char;

  // double mode sequence trackers
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      m_on_ff  <= UFC_SW_IDLE;
      m_off_ff <= UFC_SW_IDLE;
    end else if (clk_en_in && rx_valid_in) begin
      m_off_ff <= of1 ? UFC_SW_HALF : UFC_SW_IDLE;
      m_on_ff  <= on1 ? UFC_SW_HALF : UFC_SW_IDLE;
    end
  end

  // register writes
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {ier_ff, fcr_ff, lcr_ff, mcr_ff, efr_ff} <= {5{`UFC_RST_BYTE}};
      {resume_char_first_ff, resume_char_second_ff, pause_char_first_ff, pause_char_second_ff} <= {4{`UFC_RST_BYTE}};
      {txlvl_ff, rxlvl_ff, flwh_ff, flwl_ff} <= {4{`UFC_RST_BYTE}};
      pres_ff  <= `UFC_RST_BYTE;
      additional_feature_ctrl_1_ff <= `UFC_RST_BYTE;
      div_ff   <= `UFC_RST_DIV;
    end else if (clk_en_in && wr_in) begin
      if (bank_in) begin
        unique case (addr_in)
          `UFC_A_ADDITIONAL_FEATURE_CTRL_1: additional_feature_ctrl_1_ff <= wdata_in;
          default: ;
        endcase
      end else begin
        unique case (addr_in)
          `UFC_A_IER:   ier_ff   <= wdata_in;
          `UFC_A_FCR:   fcr_ff   <= wdata_in;
          `UFC_A_LCR:   lcr_ff   <= wdata_in;
          `UFC_A_MCR:   mcr_ff   <= wdata_in;
          `UFC_A_EFR:   efr_ff   <= wdata_in;
          `UFC_A_RESUME_CHAR_FIRST:  resume_char_first_ff  <= wdata_in;
          `UFC_A_RESUME_CHAR_SECOND:  resume_char_second_ff  <= wdata_in;
          `UFC_A_PAUSE_CHAR_FIRST: pause_char_first_ff <= wdata_in;
          `UFC_A_PAUSE_CHAR_SECOND: pause_char_second_ff <= wdata_in;
          `UFC_A_TXLVL: txlvl_ff <= wdata_in;
          `UFC_A_RXLVL: rxlvl_ff <= wdata_in;
          `UFC_A_FLWH:  flwh_ff  <= wdata_in;
          `UFC_A_FLWL:  flwl_ff  <= wdata_in;
          `UFC_A_DIVLO: div_ff[7:0]  <= wdata_in;
          `UFC_A_DIVHI: div_ff[15:8] <= wdata_in;
          `UFC_A_PRES:  pres_ff  <= wdata_in;
        endcase
      end
    end
  end

  // cts edge flag and previous cts level
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cts_prev_ff <= 1'b0;
      cts_flag_ff <= 1'b0;
    end else if (clk_en_in) begin
      cts_prev_ff <= cts_line;
      if (hw_en && cts_line && !cts_prev_ff && ier_ff[`UFC_IER_CTS])
        cts_flag_ff <= 1'b1;
      else if (rd_in && bank_in && addr_in == `UFC_A_ISR
               && isr_id == `UFC_ID_CTS)
        cts_flag_ff <= 1'b0;
    end
  end

  // software flow halt, set wins over clear
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      halted_ff    <= 1'b0;
      xoff_flag_ff <= 1'b0;
    end else if (clk_en_in) begin
      if (xoff_hit) begin
        halted_ff <= 1'b1;
        if (ier_ff[`UFC_IER_XOFF])
          xoff_flag_ff <= 1'b1;
      end else if (xon_hit) begin
        halted_ff    <= 1'b0;
        xoff_flag_ff <= 1'b0;
      end else if (rx_valid_in && spec_hit && ier_ff[`UFC_IER_XOFF]) begin
        xoff_flag_ff <= 1'b1;
      end else if (!sw_en) begin
        halted_ff <= 1'b0;
      end
    end
  end
  // transmitter may start a new character only at a boundary
  assign tx_allow_out = ~halted_ff & ~(hw_en & cts_line);

  // receive side flow: rts level and xon/xoff send requests
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rts_off_ff   <= 1'b0;
      xoff_sent_ff <= 1'b0;
    end else if (clk_en_in) begin
      if (rx_count_in >= hi_lvl)
        rts_off_ff <= hw_en;
      else if (rx_count_in <= lo_lvl)
        rts_off_ff <= 1'b0;
      if (sw_en && rx_count_in >= hi_lvl)
        xoff_sent_ff <= 1'b1;
      else if (rx_count_in <= lo_lvl)
        xoff_sent_ff <= 1'b0;
    end
  end
  always_comb begin
    send_xoff_out = sw_en & (rx_count_in >= hi_lvl) & ~xoff_sent_ff;
    send_xon_out  = xoff_sent_ff & (rx_count_in <= lo_lvl);
  end
  // remap steers the flow signal to dtr instead of rts
  always_comb begin
    rts_n_out = modem_rts_n_in;
    dtr_n_out = modem_dtr_n_in;
    if (hw_en && additional_feature_ctrl_1_ff[`UFC_ADDITIONAL_FEATURE_CTRL_1_MAP])
      dtr_n_out = rts_off_ff;
    else if (hw_en)
      rts_n_out = rts_off_ff;
  end

  // baud generator, fractional by 16ths
  logic [17:0] acc_ff;
  logic [1:0]  pre_ff;
  logic [21:0] div_x16;
  logic        pre_tick;
  assign div_x16  = {2'b00, div_ff, 4'h0} + {18'h0, pres_ff[3:0]};
  assign pre_tick = ~mcr_ff[`UFC_MCR_PRE4] | (pre_ff == 2'd3);
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_ff     <= 2'd0;
      acc_ff     <= 18'h0;
      baud16_out <= 1'b0;
    end else if (clk_en_in) begin
      pre_ff     <= pre_ff + 2'd1;
      baud16_out <= 1'b0;
      if (pre_tick) begin
        if ({4'h0, acc_ff} + 22'd16 >= div_x16) begin
          acc_ff     <= 18'(({4'h0, acc_ff} + 22'd16) - div_x16);
          baud16_out <= 1'b1;
        end else begin
          acc_ff <= acc_ff + 18'd16;
        end
      end
    end
  end

  // time-out in 16x ticks, 4 chars of up to 12 bits
  logic [9:0] to_ff, to_lim;
  logic [4:0] half_bits;
  // char length in half bits, 1.5 stop bits only with 5-bit words
  assign half_bits = {(4'd6 + {2'b00, lcr_ff[1:0]} + {3'b0, lcr_ff[3]}), 1'b0}
                   + (!lcr_ff[2] ? 5'd2
                      : (lcr_ff[1:0] == 2'b00) ? 5'd3 : 5'd4);
  assign to_lim = 10'(`UFC_TO_CHARS * `UFC_OVS / 2) * {5'h0, half_bits};
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      to_ff      <= 10'h0;
      to_flag_ff <= 1'b0;
    end else if (clk_en_in) begin
      if (rx_stop_in || rhr_read_in || rx_count_in == 8'h00) begin
        to_ff      <= 10'h0;
        to_flag_ff <= 1'b0;
      end else if (baud16_out) begin
        if (to_ff >= to_lim - 10'd1)
          to_flag_ff <= 1'b1;
        else
          to_ff <= to_ff + 10'd1;
      end
    end
  end

  // thr empty latch, raised from reset onward
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in)
      thr_flag_ff <= 1'b1;
    else if (clk_en_in) begin
      if (!thr_empty_in)
        thr_flag_ff <= 1'b1;
      else if (rd_in && bank_in && addr_in == `UFC_A_ISR
               && isr_id == `UFC_ID_THR)
        thr_flag_ff <= 1'b0;
    end
  end

  // single highest priority source
  assign rx_rdy = ier_ff[`UFC_IER_RX] & (rx_count_in >= rx_trig)
                & (rx_trig != 8'h00);
  always_comb begin
    if (ier_ff[`UFC_IER_RX] && to_flag_ff)
      isr_id = `UFC_ID_RXTO;
    else if (rx_rdy)
      isr_id = `UFC_ID_RXRDY;
    else if (ier_ff[`UFC_IER_THR] && thr_flag_ff && thr_empty_in)
      isr_id = `UFC_ID_THR;
    else if (xoff_flag_ff)
      isr_id = `UFC_ID_XOFF;
    else if (cts_flag_ff)
      isr_id = `UFC_ID_CTS;
    else
      isr_id = `UFC_ID_NONE;
  end
  assign irq_out = (isr_id != `UFC_ID_NONE);

  // read data one cycle after the strobe
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in)
      rdata_out <= 8'h00;
    else if (clk_en_in) begin
      rdata_out <= 8'h00;
      if (rd_in && bank_in && addr_in == `UFC_A_ISR)
        rdata_out <= isr_id;
      else if (rd_in && bank_in && addr_in == `UFC_A_ADDITIONAL_FEATURE_CTRL_1)
        rdata_out <= additional_feature_ctrl_1_ff;
      else if (rd_in && !bank_in) begin
        unique case (addr_in)
          `UFC_A_IER:   rdata_out <= ier_ff;
          `UFC_A_FCR:   rdata_out <= fcr_ff;
          `UFC_A_LCR:   rdata_out <= lcr_ff;
          `UFC_A_MCR:   rdata_out <= mcr_ff;
          `UFC_A_EFR:   rdata_out <= efr_ff;
          `UFC_A_RESUME_CHAR_FIRST:  rdata_out <= resume_char_first_ff;
          `UFC_A_RESUME_CHAR_SECOND:  rdata_out <= resume_char_second_ff;
          `UFC_A_PAUSE_CHAR_FIRST: rdata_out <= pause_char_first_ff;
          `UFC_A_PAUSE_CHAR_SECOND: rdata_out <= pause_char_second_ff;
          `UFC_A_TXLVL: rdata_out <= txlvl_ff;
          `UFC_A_RXLVL: rdata_out <= rxlvl_ff;
          `UFC_A_FLWH:  rdata_out <= flwh_ff;
          `UFC_A_FLWL:  rdata_out <= flwl_ff;
          `UFC_A_DIVLO: rdata_out <= div_ff[7:0];
          `UFC_A_DIVHI: rdata_out <= div_ff[15:8];
          `UFC_A_PRES:  rdata_out <= pres_ff;
        endcase
      end
    end
  end

  // checks
  a_xoff_halts: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && xoff_hit |=> !tx_allow_out)
    else $error("xoff match did not halt tx");
  a_xon_resumes: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && xon_hit && !xoff_hit |=> !halted_ff && !xoff_flag_ff)
    else $error("xon match did not resume");
  a_flow_no_push: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && rx_valid_in && sw_en && !dbl && (of1 || on1)
    |-> !rx_push_out)
    else $error("flow char pushed to fifo");
  a_hw_needs_both: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !hw_en |=> !rts_off_ff || $past(rx_count_in) > lo_lvl)
    else $error("rts forced without hw flow");
  a_rts_drop: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && hw_en && rx_count_in >= hi_lvl |=> rts_off_ff)
    else $error("rts not dropped at high level");
  a_cts_flag: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && hw_en && ier_ff[7] && $rose(cts_line) |=> cts_flag_ff)
    else $error("cts rise not flagged");
  a_to_clear: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && rhr_read_in |=> !to_flag_ff && to_ff == 10'h0)
    else $error("time-out not restarted");
  a_isr_single: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    to_flag_ff && ier_ff[0] |-> isr_id == `UFC_ID_RXTO)
    else $error("priority order broken");
endmodule : ufc_flow_baud

// *** ufc_remote_uart.sv ***
`timescale 1ns/10ps
// far-end uart: hands over received chars, drives its handshake lines
module ufc_remote_uart (
  input  wire logic          clock_in,
  output logic               rx_valid_out,
  output ufc_pkg::ufc_byte_t rx_char_out,
  output logic               rx_stop_out,
  output logic               cts_n_out,
  output logic               dsr_n_out
);
  import ufc_pkg::*;
  // idle line, clear to send
  initial begin
    rx_valid_out = 1'b0;
    rx_char_out  = 8'h00;
    rx_stop_out  = 1'b0;
    cts_n_out    = 1'b0;
    dsr_n_out    = 1'b0;
  end
  // one char, stop-bit centre in the same cycle; gap sets the pace
  task automatic send(input ufc_byte_t c, input int gap);
    @(posedge clock_in);
    rx_valid_out <= 1'b1;
    rx_char_out  <= c;
    rx_stop_out  <= 1'b1;
    @(posedge clock_in);
    rx_valid_out <= 1'b0;
    rx_stop_out  <= 1'b0;
    rx_char_out  <= ~c; // stale char must not pass for data
    repeat (gap) @(posedge clock_in);
  endtask : send
  // raise or return the remote clear-to-send, on cts or dsr wire
  task automatic hold_off(input logic stop_n, input logic on_dsr);
    @(posedge clock_in);
    if (on_dsr)
      dsr_n_out <= stop_n;
    else
      cts_n_out <= stop_n;
  endtask : hold_off
endmodule : ufc_remote_uart

// *** tb_top.sv ***
`timescale 1ns/10ps
`include "ufc_consts.svh"
module tb_top;
  import ufc_pkg::*;
  logic       clock_in, rst_n_in, wr_in, rd_in, bank_in, rhr_rd;
  logic [3:0] addr_in;
  ufc_byte_t  wdata_in, rdata_out, rx_char, v;
  logic [7:0] count, tk;
  logic       rx_valid, rx_stop, cts_n, dsr_n, rd_pend;
  logic       push, allow, xoff_rq, xon_rq, rts_n, dtr_n, b16, irq;
  logic       thr_mt, ce;
  int         err_count, num_checks;
  integer     seed;
  ufc_byte_t  rd_q[$];
  logic       push_q[$];
  ufc_byte_t  bt[3][4] = '{'{8'h03, 8'h00, 8'h00, 8'd40},
    '{8'h02, 8'h08, 8'h00, 8'd48}, '{8'h01, 8'h00, 8'h80, 8'd30}};
  ufc_flow_baud u_dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .clk_en_in(ce), .addr_in(addr_in), .bank_in(bank_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .rx_valid_in(rx_valid),
    .rx_char_in(rx_char), .rx_stop_in(rx_stop), .rx_count_in(count),
    .rhr_read_in(rhr_rd), .tx_char_done_in(1'b0), .thr_empty_in(thr_mt),
    .cts_n_in(cts_n), .dsr_n_in(dsr_n), .modem_rts_n_in(1'b0),
    .modem_dtr_n_in(1'b1), .rx_push_out(push), .tx_allow_out(allow),
    .send_xoff_out(xoff_rq), .send_xon_out(xon_rq), .rts_n_out(rts_n),
    .dtr_n_out(dtr_n), .baud16_out(b16), .irq_out(irq));
  ufc_remote_uart u_remote (.clock_in(clock_in), .rx_valid_out(rx_valid),
    .rx_char_out(rx_char), .rx_stop_out(rx_stop), .cts_n_out(cts_n),
    .dsr_n_out(dsr_n));
  // 40 mhz clock
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  task automatic cmp_byte(input string n, input ufc_byte_t e,
                          input ufc_byte_t g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask : cmp_byte
  task automatic cmp_bit(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s exp %b got %b", n, e, g);
    end
  endtask : cmp_bit
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  // read data stand in the cycle after the strobe
  always @(posedge clock_in) begin
    if (rd_pend)
      cmp_byte("rdata", rd_q.pop_front(), rdata_out);
    rd_pend <= rd_in;
  end
  // fifo write decision seen while the char is offered
  always @(negedge clock_in) begin
    if (rx_valid && push_q.size() > 0)
      cmp_bit("push", push_q.pop_front(), push);
  end
  task automatic wr(input logic b, input logic [3:0] a, input ufc_byte_t d);
    @(posedge clock_in);
    wr_in    <= 1'b1;
    bank_in  <= b;
    addr_in  <= a;
    wdata_in <= d;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic b, input logic [3:0] a, input ufc_byte_t e);
    rd_q.push_back(e);
    @(posedge clock_in);
    rd_in   <= 1'b1;
    bank_in <= b;
    addr_in <= a;
    @(posedge clock_in);
    rd_in <= 1'b0;
  endtask : rd
  task automatic look;
    repeat (3) @(negedge clock_in);
  endtask : look
  task automatic setc(input logic [7:0] n);
    @(posedge clock_in);
    count <= n;
    look();
  endtask : setc
  task automatic snd(input ufc_byte_t c, input logic chk, input logic e);
    if (chk)
      push_q.push_back(e);
    u_remote.send(c, 2);
    look();
  endtask : snd
  task automatic rhr_pulse;
    @(posedge clock_in);
    rhr_rd <= 1'b1;
    @(posedge clock_in);
    rhr_rd <= 1'b0;
  endtask : rhr_pulse
  // cut a hang short
  initial begin
    #(25 * 20000);
    err_count++;
    end_of_test();
  end
  // main sequence
  initial begin
    {wr_in, rd_in, bank_in, rhr_rd, rd_pend} = '0;
    {addr_in, wdata_in, count} = '0;
    seed = 32'hd088f7f1;
    {thr_mt, ce} = 2'b11;
    rst_n_in = 1'b0;
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    for (int a = 5; a <= 8; a++)
      rd(0, 4'(a), 8'h00);
    rd(0, `UFC_A_DIVLO, 8'h01);
    rd(1, `UFC_A_ISR, `UFC_ID_NONE);
    wr(0, `UFC_A_IER, 8'h02);
    rd(1, `UFC_A_ISR, `UFC_ID_THR);
    rd(1, `UFC_A_ISR, `UFC_ID_NONE);
    wr(0, `UFC_A_IER, 8'h00);
    rd(1, 4'h5, 8'h00);
    for (int a = 5; a <= 8; a++) begin
      v = 8'($random(seed));
      wr(0, 4'(a), v);
      rd(0, 4'(a), v);
    end
    // receive time-out: 8n1 char is 160 ticks at divisor 1
    wr(0, `UFC_A_LCR, 8'h03);
    wr(0, `UFC_A_IER, 8'h01);
    setc(8'd1);
    rhr_pulse();
    repeat (580) @(posedge clock_in);
    rd(1, `UFC_A_ISR, `UFC_ID_NONE);
    repeat (100) @(posedge clock_in);
    rd(1, `UFC_A_ISR, `UFC_ID_RXTO);
    rhr_pulse();
    rd(1, `UFC_A_ISR, `UFC_ID_NONE);
    setc(8'd8);
    rd(1, `UFC_A_ISR, `UFC_ID_RXRDY);
    wr(0, `UFC_A_IER, 8'h00);
    rd(1, `UFC_A_ISR, `UFC_ID_NONE);
    // legacy thresholds, code 01: stop 16, restart 7
    wr(0, `UFC_A_FCR, 8'h51);
    wr(0, `UFC_A_EFR, 8'hC0);
    setc(8'd15);
    cmp_bit("rts", 1'b0, rts_n);
    setc(8'd16);
    cmp_bit("rts", 1'b1, rts_n);
    snd(8'h5A, 1, 1);
    setc(8'd8);
    cmp_bit("rts", 1'b1, rts_n);
    setc(8'd7);
    cmp_bit("rts", 1'b0, rts_n);
    wr(0, `UFC_A_EFR, 8'h40);
    setc(8'd20);
    cmp_bit("rts", 1'b0, rts_n);
    // cts halt and its status flag
    wr(0, `UFC_A_EFR, 8'hC0);
    wr(0, `UFC_A_IER, 8'h80);
    u_remote.hold_off(1'b1, 1'b0);
    look();
    cmp_bit("allow", 1'b0, allow);
    rd(1, `UFC_A_ISR, `UFC_ID_CTS);
    rd(1, `UFC_A_ISR, `UFC_ID_NONE);
    u_remote.hold_off(1'b0, 1'b0);
    look();
    cmp_bit("allow", 1'b1, allow);
    // handshake moved onto dsr and dtr
    wr(0, `UFC_A_IER, 8'h00);
    wr(1, `UFC_A_ADDITIONAL_FEATURE_CTRL_1, 8'h04);
    look();
    cmp_bit("dtr", 1'b1, dtr_n);
    cmp_bit("rts", 1'b0, rts_n);
    u_remote.hold_off(1'b1, 1'b1);
    look();
    cmp_bit("allow", 1'b0, allow);
    u_remote.hold_off(1'b0, 1'b1);
    wr(1, `UFC_A_ADDITIONAL_FEATURE_CTRL_1, 8'h00);
    setc(8'd0);
    // extended counts, set before flow is enabled
    wr(0, `UFC_A_EFR, 8'h00);
    wr(0, `UFC_A_RXLVL, 8'h40);
    wr(0, `UFC_A_FLWL, 8'h7F);
    wr(0, `UFC_A_FLWH, 8'h80);
    wr(0, `UFC_A_EFR, 8'hC0);
    setc(8'd127);
    cmp_bit("rts", 1'b0, rts_n);
    setc(8'd128);
    cmp_bit("rts", 1'b1, rts_n);
    wr(0, `UFC_A_EFR, 8'h00);
    wr(0, `UFC_A_FLWL, 8'h04);
    wr(0, `UFC_A_FLWH, 8'h0A);
    wr(0, `UFC_A_EFR, 8'hC0);
    setc(8'd10);
    cmp_bit("rts", 1'b1, rts_n);
    setc(8'd5);
    cmp_bit("rts", 1'b1, rts_n);
    setc(8'd4);
    cmp_bit("rts", 1'b0, rts_n);
    // single xon 11 / xoff 13, cts flag queued behind xoff flag
    for (int a = 5; a <= 8; a++)
      wr(0, 4'(a), (a < 7) ? 8'h11 : 8'h13);
    wr(0, `UFC_A_IER, 8'hA0);
    wr(0, `UFC_A_EFR, 8'hCA);
    snd(8'h13, 1, 0);
    cmp_bit("allow", 1'b0, allow);
    cmp_bit("irq", 1'b1, irq);
    snd(8'($random(seed)) | 8'h80, 1, 1);
    u_remote.hold_off(1'b1, 1'b0);
    u_remote.hold_off(1'b0, 1'b0);
    rd(1, `UFC_A_ISR, `UFC_ID_XOFF);
    snd(8'h11, 1, 0);
    cmp_bit("allow", 1'b1, allow);
    rd(1, `UFC_A_ISR, `UFC_ID_CTS);
    rd(1, `UFC_A_ISR, `UFC_ID_NONE);
    // send requests stand for one cycle only
    @(posedge clock_in);
    count <= 8'd10;
    @(negedge clock_in);
    cmp_bit("xoff_rq", 1'b1, xoff_rq);
    look();
    cmp_bit("xoff_rq", 1'b0, xoff_rq);
    @(posedge clock_in);
    count <= 8'd3;
    @(negedge clock_in);
    cmp_bit("xon_rq", 1'b1, xon_rq);
    look();
    cmp_bit("xon_rq", 1'b0, xon_rq);
    cmp_bit("xoff_rq", 1'b0, xoff_rq);
    // 5-bit word: upper bits ignored in the match
    wr(0, `UFC_A_LCR, 8'h00);
    snd(8'hF3, 1, 0);
    cmp_bit("allow", 1'b0, allow);
    snd(8'hF1, 1, 0);
    cmp_bit("allow", 1'b1, allow);
    wr(0, `UFC_A_LCR, 8'h03);
    // double chars: xon 11 12, xoff 13 14
    wr(0, `UFC_A_RESUME_CHAR_SECOND, 8'h12);
    wr(0, `UFC_A_PAUSE_CHAR_SECOND, 8'h14);
    wr(0, `UFC_A_EFR, 8'h0F);
    snd(8'h13, 1, 0);
    cmp_bit("allow", 1'b1, allow);
    snd(8'h14, 1, 0);
    cmp_bit("allow", 1'b0, allow);
    snd(8'h11, 1, 0);
    snd(8'h12, 1, 0);
    cmp_bit("allow", 1'b1, allow);
    // special char is stored and flagged
    wr(0, `UFC_A_PAUSE_CHAR_SECOND, 8'h55);
    wr(0, `UFC_A_EFR, 8'h20);
    snd(8'h55, 1, 1);
    rd(1, `UFC_A_ISR, `UFC_ID_XOFF);
    // baud16 ticks in 120 cycles: n=3, n=2.5, prescale 4
    for (int i = 0; i < 3; i++) begin
      wr(0, `UFC_A_DIVLO, bt[i][0]);
      wr(0, `UFC_A_PRES, bt[i][1]);
      wr(0, `UFC_A_MCR, bt[i][2]);
      repeat (10) @(posedge clock_in);
      tk = 8'h00;
      repeat (120) @(posedge clock_in) tk = tk + {7'h00, b16};
      cmp_byte("ticks", bt[i][3], tk);
    end
    // a write with the clock enable low must not land
    @(posedge clock_in);
    ce <= 1'b0;
    wr(0, `UFC_A_RESUME_CHAR_FIRST, 8'hA5);
    @(posedge clock_in);
    ce <= 1'b1;
    rd(0, `UFC_A_RESUME_CHAR_FIRST, 8'h11);
    end_of_test();
  end
endmodule : tb_top
